// file: spmp_pkg.sv
package spmp_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_STATUS  = 32'hffff_0a00;  // serial_port_status
    localparam logic [31:0] ADDR_RX      = 32'hffff_0a04;  // receive_holding
    localparam logic [31:0] ADDR_TX      = 32'hffff_0a08;  // transmit_holding
    localparam logic [31:0] ADDR_DIV     = 32'hffff_0a0c;  // bit_rate_divider
    localparam logic [31:0] ADDR_CTRL    = 32'hffff_0a10;  // port_control

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [7:0]  RST_DIV      = 8'h1b;
    localparam logic [15:0] RST_CTRL     = 16'h0000;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int ST_TX_FULL  = 0;   // Transmit holding occupied
    localparam int ST_TX_IRQ   = 1;   // Transmit interrupt source
    localparam int ST_TX_UND   = 2;   // Transmit underflow
    localparam int ST_RX_FULL  = 3;   // Receive holding valid
    localparam int ST_RX_IRQ   = 4;   // Receive interrupt source
    localparam int ST_RX_OVF   = 5;   // Receive overflow

    // ------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------
    localparam int CT_ENABLE   = 0;   // Port enable
    localparam int CT_MASTER   = 1;   // Master mode
    localparam int CT_CPHA     = 2;   // Clock phase
    localparam int CT_CPOL     = 3;   // Clock idle polarity
    localparam int CT_LSB      = 5;   // Least significant bit first
    localparam int CT_TXMODE   = 6;   // Transfer/interrupt mode
    localparam int CT_UND_ZERO = 7;   // Underflow sends zero
    localparam int CT_OVR_WR   = 8;   // Overflow overwrites
    localparam int CT_CS_OFF   = 9;   // Chip select output disabled
    localparam int CT_MISO_OD  = 10;  // Data out open drain
    localparam int CT_LOOP     = 11;  // Loop back

    // ------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------
    localparam logic [3:0]  LAST_EDGE    = 4'hf;  // 16 edges = 8 periods

    // Engine states
    typedef enum logic {
        SPMP_IDLE  = 1'b0,
        SPMP_SHIFT = 1'b1
    } spmp_state_t;

    // Register port request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } spmp_bus_t;

endpackage

// file: spmp_port.sv
module spmp_port (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               rst_n_i,
    // Register port
    input  wire spmp_pkg::spmp_bus_t bus_i,
    output logic [31:0]             rdata_o,
    // Interrupt
    output logic                    irq_o,
    // Serial clock pin
    input  wire logic               sclk_i,
    output logic                    sclk_o,
    output logic                    sclk_oe_o,
    // Master-in data pin
    input  wire logic               miso_i,
    output logic                    miso_o,
    output logic                    miso_oe_o,
    // Master-out data pin
    input  wire logic               mosi_i,
    output logic                    mosi_o,
    output logic                    mosi_oe_o,
    // Chip select pin
    input  wire logic               cs_n_i,
    output logic                    cs_n_o,
    output logic                    cs_n_oe_o
);
    import spmp_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [15:0]  ctrl;          // port_control
    logic [7:0]   div;           // bit_rate_divider
    logic [7:0]   tx_hold;       // transmit_holding
    logic [7:0]   rx_hold;       // receive_holding
    logic [7:0]   stat;          // serial_port_status
    logic [7:0]   sh_tx;         // Transmit shift register
    logic [7:0]   sh_rx;         // Receive shift register
    logic [7:0]   half_cnt;      // Master half-period counter
    logic [3:0]   edge_cnt;      // Clock edges done in byte
    logic         sck_lvl;       // Master clock phase level
    logic         rd_pend;       // Read-started transfer pending
    spmp_state_t  state;         // Engine state
    // Synchronisers: stage one feeds stage two only
    logic         sclk_s1, sclk_s2, sclk_s3;
    logic         cs_s1, cs_s2;
    logic         miso_s1, miso_s2;
    logic         mosi_s1, mosi_s2;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic master, en, lsb, cpha, busy;
    logic wr_tx, rd_rx, lead, trail, load, done, tx_out, din;
    logic [7:0] next_rx;

    assign en     = ctrl[CT_ENABLE];
    assign master = ctrl[CT_MASTER];
    assign lsb    = ctrl[CT_LSB];
    assign cpha   = ctrl[CT_CPHA];
    assign busy   = (state == SPMP_SHIFT);
    assign wr_tx  = bus_i.wr && (bus_i.addr == ADDR_TX);
    assign rd_rx  = bus_i.rd && (bus_i.addr == ADDR_RX);

    // Edges: master from its own counter, slave from synced pin
    always_comb begin
        lead  = 1'b0;
        trail = 1'b0;
        if (busy && master) begin
            lead  = (half_cnt == div) && !sck_lvl;
            trail = (half_cnt == div) && sck_lvl;
        end else if (busy) begin
            // Polarity folded out so leading is always a rise
            lead  = ((sclk_s2 ^ ctrl[CT_CPOL]) && !(sclk_s3 ^ ctrl[CT_CPOL]));
            trail = (!(sclk_s2 ^ ctrl[CT_CPOL]) && (sclk_s3 ^ ctrl[CT_CPOL]));
        end
    end

    // Outgoing bit and incoming bit
    assign tx_out = lsb ? sh_tx[0] : sh_tx[7];
    assign din    = ctrl[CT_LOOP] ? tx_out : (master ? miso_s2 : mosi_s2);

    // Sample on leading edge for phase 0, trailing for phase 1
    logic smp;
    assign smp     = cpha ? trail : lead;
    assign next_rx = !smp ? sh_rx : (lsb ? {din, sh_rx[7:1]} : {sh_rx[6:0], din});
    assign done    = trail && (edge_cnt == LAST_EDGE);

    // Start conditions
    always_comb begin
        load = 1'b0;
        if (en && !busy && master) begin
            load = ctrl[CT_TXMODE] ? stat[ST_TX_FULL] : rd_pend;
        end else if (en && !master && !cs_s2) begin
            load = !busy || done;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Pins from the far party are asynchronous to the core clock
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1   <= 1'b1;
            cs_s2   <= 1'b1;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
            mosi_s1 <= 1'b0;
            mosi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1   <= cs_n_i;
            cs_s2   <= cs_s1;
            miso_s1 <= miso_i;
            miso_s2 <= miso_s1;
            mosi_s1 <= mosi_i;
            mosi_s2 <= mosi_s1;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Control, divider and transmit holding writes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl    <= RST_CTRL;
            div     <= RST_DIV;
            tx_hold <= RST_BYTE;
        end else if (bus_i.wr) begin
            if (bus_i.addr == ADDR_CTRL) begin
                ctrl <= bus_i.wdata[15:0] & 16'h1fef;  // Bits 4 and 13-15 stay 0; unnamed bit 12 is writable
            end
            if (bus_i.addr == ADDR_DIV) begin
                div <= bus_i.wdata[7:0];
            end
            if (wr_tx) begin
                tx_hold <= bus_i.wdata[7:0];
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                ADDR_STATUS: rdata_o <= {24'h00_0000, stat};
                ADDR_RX:     rdata_o <= {24'h00_0000, rx_hold};
                ADDR_DIV:    rdata_o <= {24'h00_0000, div};
                ADDR_CTRL:   rdata_o <= {16'h0000, ctrl};
                default:     rdata_o <= 32'h0000_0000;  // Write-only or unmapped
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // Read of receive holding requests a master transfer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rd_pend <= 1'b0;
        end else if (rd_rx && master && !ctrl[CT_TXMODE]) begin
            rd_pend <= 1'b1;
        end else if (load || !master || ctrl[CT_TXMODE]) begin
            rd_pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    // State: master stops after one byte; slave aborts on select release
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state <= SPMP_IDLE;
        end else if (load) begin
            state <= SPMP_SHIFT;
        end else if (done || !en || (!master && cs_s2)) begin
            state <= SPMP_IDLE;
        end
    end

    // Master clock divider and phase level
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            half_cnt <= 8'h00;
            sck_lvl  <= 1'b0;
        end else if (!busy || load || !master) begin
            half_cnt <= 8'h00;
            sck_lvl  <= 1'b0;
        end else if (half_cnt == div) begin
            half_cnt <= 8'h00;
            sck_lvl  <= !sck_lvl;
        end else begin
            half_cnt <= half_cnt + 8'h01;
        end
    end

    // Edge counter within the byte
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            edge_cnt <= 4'h0;
        end else if (load || !busy) begin
            edge_cnt <= 4'h0;
        end else if (lead || trail) begin
            edge_cnt <= edge_cnt + 4'h1;
        end
    end

    // Transmit shift: phase 1 launches on leading edges past the first
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sh_tx <= RST_BYTE;
        end else if (load) begin
            // Underflow sends zero or repeats the last byte
            sh_tx <= (!stat[ST_TX_FULL] && ctrl[CT_UND_ZERO]) ? 8'h00 : tx_hold;
        end else if ((cpha ? (lead && edge_cnt != 4'h0) : trail)) begin
            sh_tx <= lsb ? {1'b0, sh_tx[7:1]} : {sh_tx[6:0], 1'b0};
        end
    end

    // Receive shift
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sh_rx <= RST_BYTE;
        end else if (load && !busy) begin
            sh_rx <= RST_BYTE;
        end else begin
            sh_rx <= next_rx;
        end
    end

    // ------------------------------------------------------------
    // Receive holding and status
    // ------------------------------------------------------------
    // New byte lands unless holding is full, not read this cycle, and overwrite is off
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_hold <= RST_BYTE;
        end else if (done && (!stat[ST_RX_FULL] || rd_rx || ctrl[CT_OVR_WR])) begin
            rx_hold <= next_rx;
        end
    end

    // Status flags; a hardware set beats a same-cycle software clear, except the transmit interrupt source, cleared by the write
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            stat <= RST_BYTE;
        end else begin
            // Transmit holding occupancy
            if (wr_tx) begin
                stat[ST_TX_FULL] <= 1'b1;
            end else if (load) begin
                stat[ST_TX_FULL] <= 1'b0;
            end
            // Underflow: shift loaded from an empty holding
            if (load && !stat[ST_TX_FULL]) begin
                stat[ST_TX_UND] <= 1'b1;
            end else if (wr_tx) begin
                stat[ST_TX_UND] <= 1'b0;
            end
            // Transmit interrupt source
            if (wr_tx || (!en && !busy)) begin
                stat[ST_TX_IRQ] <= 1'b0;
            end else if (!stat[ST_TX_FULL] || stat[ST_TX_UND]) begin
                stat[ST_TX_IRQ] <= 1'b1;
            end
            // Receive full, overflow, interrupt
            if (done) begin
                stat[ST_RX_FULL] <= 1'b1;
                stat[ST_RX_IRQ]  <= 1'b1;
                if (stat[ST_RX_FULL] && !rd_rx) begin
                    stat[ST_RX_OVF] <= 1'b1;
                end else if (rd_rx) begin
                    stat[ST_RX_OVF] <= 1'b0;
                end
            end else if (rd_rx) begin
                stat[ST_RX_FULL] <= 1'b0;
                stat[ST_RX_OVF]  <= 1'b0;
                stat[ST_RX_IRQ]  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Only one source reaches the line, picked by transfer mode
    assign irq_o     = ctrl[CT_TXMODE] ? stat[ST_TX_IRQ] : stat[ST_RX_IRQ];
    assign sclk_o    = sck_lvl ^ ctrl[CT_CPOL];
    assign sclk_oe_o = master;
    assign mosi_o    = tx_out;
    assign mosi_oe_o = master;
    // Open drain mode only ever pulls low
    assign miso_o    = ctrl[CT_MISO_OD] ? 1'b0 : tx_out;
    assign miso_oe_o = !master && en && !cs_s2 && (!ctrl[CT_MISO_OD] || !tx_out);
    assign cs_n_o    = !busy;
    assign cs_n_oe_o = master && !ctrl[CT_CS_OFF];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    tx_full_set_a: assert property (wr_tx |=> stat[ST_TX_FULL])
        else $error("Transmit full not set after write");
    rx_read_clr_a: assert property (rd_rx && !done |=> !stat[ST_RX_FULL] && !stat[ST_RX_IRQ])
        else $error("Receive flags not cleared by read");
    ovf_set_a: assert property (done && stat[ST_RX_FULL] && !rd_rx |=> stat[ST_RX_OVF])
        else $error("Overflow not flagged");
    rx_irq_a: assert property ((stat[ST_RX_FULL] || stat[ST_RX_OVF]) |-> stat[ST_RX_IRQ])
        else $error("Receive irq missing");
    und_set_a: assert property (load && !stat[ST_TX_FULL] |=> stat[ST_TX_UND])
        else $error("Underflow not flagged");
    irq_sel_a: assert property (ctrl[CT_TXMODE] && en && !stat[ST_TX_FULL] && !bus_i.wr |=> irq_o)
        else $error("Interrupt source wrong");
    clk_idle_a: assert property (!busy |-> sclk_o == ctrl[CT_CPOL])
        else $error("Clock not idle");
    half_per_a: assert property (busy && master && $changed(sck_lvl) && !done |=> !$changed(sck_lvl))
        else $error("Clock half period too short");
    slave_rearm_a: assert property (done && en && !master && !cs_s2 |=> busy && edge_cnt == 4'h0)
        else $error("Slave did not rearm while selected");
    pin_dir_a: assert property (master |-> mosi_oe_o && sclk_oe_o && !miso_oe_o)
        else $error("Pin direction wrong in master");

    master_byte_c: cover property (done && master);
    slave_byte_c: cover property (done && !master);
    overflow_c: cover property (done && stat[ST_RX_FULL] && !rd_rx);
    underflow_c: cover property (load && !stat[ST_TX_FULL]);

endmodule // spmp_port

// file: spmp_peer.sv
// Far-side serial device: slave while the port masters, master otherwise
module spmp_peer (
    // Core clock for pacing
    input  wire logic       clk_i,
    // Resolved wires
    input  wire logic       sclk_w_i,
    input  wire logic       cs_n_w_i,
    input  wire logic       din_i,
    // Shared mode
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       lsb_i,
    input  wire logic [7:0] tx_i,
    // Driven pins
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic            dout_o,
    output logic [7:0]      rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int      edges    = 0;     // Clock edges seen in frame
    realtime t_first  = 0;     // First edge time
    realtime t_last   = 0;     // Latest edge time
    logic    last_bit = 1'b0;  // Level before release
    int      idx;              // Bit being launched
    logic    cs_seen  = 1'b1;  // Select as it stood before this edge
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        rx_o   = 8'h00;
    end
    // -------------------------------------------------------
    // Launch: bit 0 shows before any edge; phase picks trailing or leading edges for the later bits
    // -------------------------------------------------------
    always_comb begin
        idx = cpha_i ? ((edges == 0) ? 0 : (edges - 1) / 2) : edges / 2;
        if (idx > 7) begin
            idx = 7;
        end
    end
    // Released line shows inverse of last level, not a stale copy
    assign dout_o = cs_n_w_i ? ~last_bit : tx_i[lsb_i ? idx : 7 - idx];
    always @(posedge cs_n_w_i) begin
        last_bit = tx_i[lsb_i ? idx : 7 - idx];
    end
    always @(negedge cs_n_w_i) begin
        edges = 0;
    end
    // Select sampled mid-cycle: a release at the last edge still counts it
    always @(negedge clk_i) begin
        cs_seen = cs_n_w_i;
    end
    // Sample on the edge opposite launch, same polarity and phase
    always @(sclk_w_i) begin
        if (!cs_seen) begin
            if ((edges % 2) == (cpha_i ? 1 : 0)) begin
                rx_o = lsb_i ? {din_i, rx_o[7:1]} : {rx_o[6:0], din_i};
            end
            if (edges == 0) begin
                t_first = $realtime;
            end
            t_last = $realtime;
            edges  = edges + 1;
        end
    end
    // One byte as master; half period of four core cycles stays below quarter rate
    task automatic frame();
        sclk_o <= cpol_i;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (16) begin
            repeat (4) @(posedge clk_i);
            sclk_o <= ~sclk_o;
        end
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
    endtask
endmodule  // spmp_peer

// file: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import spmp_pkg::*;
    // -------------------------------------------------------
    // Signals
    // -------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    spmp_bus_t   bus     = '0;
    logic [31:0] rdata, v;
    logic        irq, sclk_o, sclk_oe, miso_o, miso_oe, mosi_o, mosi_oe, cs_n_o, cs_n_oe;
    logic        p_sclk, p_cs_n, p_dout;
    logic [7:0]  p_rx, a, p_tx = 8'h00;
    logic        cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, master = 1'b0;
    int          failures = 0, checks = 0, seed = 32'h66e9, m;
    // Wire levels from the port's enables; the peer drives when they are off
    wire sclk_w = sclk_oe ? sclk_o : p_sclk;
    wire cs_n_w = cs_n_oe ? cs_n_o : p_cs_n;
    wire miso_w = miso_oe ? miso_o : p_dout;
    wire mosi_w = mosi_oe ? mosi_o : p_dout;
    logic [31:0] regs [6] = '{ADDR_STATUS, ADDR_RX, ADDR_TX, ADDR_DIV, ADDR_CTRL, 32'hffff_0a14};
    logic [31:0] rstv [6] = '{32'h0, 32'h0, 32'h0, {24'h0, RST_DIV}, {16'h0, RST_CTRL}, 32'h0};
    spmp_port spmp_port_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .bus_i(bus), .rdata_o(rdata),
        .irq_o(irq), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe_o(miso_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_o(mosi_oe), .cs_n_i(cs_n_w), .cs_n_o(cs_n_o), .cs_n_oe_o(cs_n_oe));
    spmp_peer spmp_peer_i (.clk_i(ref_clk), .sclk_w_i(sclk_w), .cs_n_w_i(cs_n_w),
        .din_i(master ? mosi_w : miso_w), .cpol_i(cpol), .cpha_i(cpha), .lsb_i(lsb),
        .tx_i(p_tx), .sclk_o(p_sclk), .cs_n_o(p_cs_n), .dout_o(p_dout), .rx_o(p_rx));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // -------------------------------------------------------
    // Helpers
    // -------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        bus.addr  <= ad;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge ref_clk);
        bus.wr    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] ad, output logic [31:0] d);
        @(posedge ref_clk);
        bus.addr <= ad;
        bus.rd   <= 1'b1;
        @(posedge ref_clk);
        bus.rd   <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    function automatic logic [31:0] ctrl(input logic mst, input logic txm, input logic und0);
        return {24'h0, und0, txm, lsb, 1'b0, cpol, cpha, mst, 1'b1};
    endfunction
    function automatic logic [31:0] st(input logic txf, und, rxf, ovf);
        return {26'h0, ovf, rxf | ovf, rxf, und, ~txf | und, txf};
    endfunction
    // Bounded wait for one framed byte, then let the syncs settle
    task automatic wait_frame();
        int n = 0;
        while (cs_n_w && n < 3000) begin @(posedge ref_clk); n++; end
        while (!cs_n_w && n < 3000) begin @(posedge ref_clk); n++; end
        if (n >= 3000) chk("frame", 32'h1, 32'h0);
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end
    // -------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (m = 0; m < 6; m++) begin rd(regs[m], v); chk("reset value", rstv[m], v); end
        wr(ADDR_STATUS, 32'hff);
        rd(ADDR_STATUS, v); chk("status ro", 32'h0, v);
        wr(ADDR_DIV, 32'h5);
        $display("test registers done");
        master = 1'b1;
        for (m = 0; m < 8; m++) begin
            {lsb, cpha, cpol} = m[2:0];
            a    = 8'($random(seed));
            p_tx = 8'($random(seed));
            wr(ADDR_CTRL, ctrl(1'b1, 1'b1, 1'b0));
            wr(ADDR_TX, {24'h0, a});
            wait_frame();
            chk("mosi byte", {24'h0, a}, {24'h0, p_rx});
            chk("edges", 32'd16, 32'(spmp_peer_i.edges));
            chk("span", 32'd9000, 32'(int'(spmp_peer_i.t_last - spmp_peer_i.t_first)));
            chk("sclk idle", {31'h0, cpol}, {31'h0, sclk_w});
            chk("pin dirs", 32'h3, {29'h0, miso_oe, sclk_oe, mosi_oe});
            chk("irq tx", 32'h1, {31'h0, irq});
            rd(ADDR_STATUS, v); chk("status full", st(0, 0, 1, 0), v);
            // Second byte unread: kept at 7, overwritten at 6
            if (m >= 6) begin
                wr(ADDR_CTRL, ctrl(1'b1, 1'b1, 1'b0) | {23'h0, m == 6, 8'h0});
                a    = p_tx;
                p_tx = ~p_tx;
                wr(ADDR_TX, 32'h5a);
                wait_frame();
                chk("mosi again", 32'h5a, {24'h0, p_rx});
                rd(ADDR_STATUS, v); chk("status ovf", st(0, 0, 1, 1), v);
            end
            rd(ADDR_RX, v); chk("rx byte", {24'h0, (m == 7) ? a : p_tx}, v);
            rd(ADDR_STATUS, v); chk("status read", st(0, 0, 0, 0), v);
        end
        $display("test master done");
        {lsb, cpha, cpol} = 3'b000;
        wr(ADDR_CTRL, ctrl(1'b1, 1'b0, 1'b1));
        rd(ADDR_RX, v);
        wait_frame();
        chk("underflow byte", 32'h0, {24'h0, p_rx});
        rd(ADDR_STATUS, v); chk("status und", st(0, 1, 1, 0), v);
        chk("irq rx", 32'h1, {31'h0, irq});
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_RX, v);
        $display("test underflow done");
        master = 1'b0;
        for (m = 0; m < 4; m++) begin
            {cpha, cpol} = m[1:0];
            lsb  = m[0] ^ m[1];
            a    = 8'($random(seed));
            p_tx = 8'($random(seed));
            wr(ADDR_CTRL, ctrl(1'b0, 1'b1, 1'b0));
            wr(ADDR_TX, {24'h0, a});
            chk("slave dirs", 32'h0, {30'h0, sclk_oe, mosi_oe});
            spmp_peer_i.frame();
            repeat (6) @(posedge ref_clk);
            chk("miso byte", {24'h0, a}, {24'h0, p_rx});
            rd(ADDR_STATUS, v); chk("slave status", st(0, 1, 1, 0), v);
            rd(ADDR_RX, v); chk("slave rx", {24'h0, p_tx}, v);
        end
        $display("test slave done");
        conclude();
    end
endmodule  // testbench
